//--- rtl/psr_pkg.sv
// Constants for the position and full status read frame handler.
// Assumes a byte-level LIN protocol layer on the same clock.
package psr_pkg;
    // =====================================================
    // Frame identifiers and command codes
    localparam logic [5:0] ID_LONG_PREP = 6'h3c;
    localparam logic [5:0] ID_READ      = 6'h3d;
    localparam logic [6:0] CMD_POS      = 7'h00;
    localparam logic [6:0] CMD_FULL     = 7'h01;
    localparam logic [7:0] APP_MARKER   = 8'h80;
    localparam logic [7:0] PAD_BYTE     = 8'hff;
    // Last byte index (checksum) of each frame kind
    localparam logic [3:0] LAST_SHORT   = 4'h2;
    localparam logic [3:0] LAST_LONG    = 4'h8;
    localparam logic [3:0] LAST_RESP    = 4'h8;
    // =====================================================
    // Register map
    localparam logic [2:0] REG_NODE     = 3'h0;
    localparam logic [2:0] REG_DYN_ID   = 3'h1;
    localparam logic [2:0] REG_IRQ_ST   = 3'h2;
    localparam logic [2:0] REG_IRQ_MASK = 3'h3;
    localparam logic [2:0] REG_FLAGS_LO = 3'h4;
    localparam logic [2:0] REG_FLAGS_HI = 3'h5;
    localparam logic [2:0] REG_DEV_ID   = 3'h6;
    localparam logic [6:0] RST_NODE     = 7'h00;
    localparam logic [4:0] RST_DYN_ID   = 5'h00;
    localparam logic [2:0] RST_MASK     = 3'h0;
    // Interrupt status bits
    localparam int IRQ_PREP = 0;
    localparam int IRQ_RESP = 1;
    localparam int IRQ_LERR = 2;
    // =====================================================
    // Latched flag positions
    localparam int F_TWRN  = 0;
    localparam int F_TSHD  = 1;
    localparam int F_UVLO  = 2;
    localparam int F_EDEF  = 3;
    localparam int F_LOST  = 4;
    localparam int F_VDD   = 5;
    localparam int F_UVLO2 = 6;
    localparam int F_UVLO3 = 7;
    localparam int F_OVCX  = 8;
    localparam int F_OVCY  = 9;
    localparam int F_STALL = 10;
    localparam int F_ABS   = 11;
    localparam int NFLAGS  = 12;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RX   = 3'b010,
        ST_TX   = 3'b100
    } psr_state_t;

    typedef enum logic [3:0] {
        PEND_NONE  = 4'b0001,
        PEND_POS   = 4'b0010,
        PEND_FULL1 = 4'b0100,
        PEND_FULL2 = 4'b1000
    } psr_pend_t;
endpackage

//--- rtl/psr_sum_if.sv
// Link between the frame handler and its checksum accumulator.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface psr_sum_if;
    logic       clr;
    logic       add;
    logic [7:0] din;
    logic [7:0] sum;
    modport user   (output clr, output add, output din, input sum);
    modport engine (input clr, input add, input din, output sum);
endinterface
`default_nettype wire

//--- rtl/psr_parity.sv
// Protected identifier builder: adds the two parity bits.
// Pure combinational; fed from the handler's own clock domain.
`timescale 1ns/1ps
`default_nettype none
module psr_parity (
    input  wire logic [5:0] id,
    output logic      [7:0] pid
);
    wire p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    wire p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    assign pid = {p1, p0, id};
endmodule
`default_nettype wire

//--- rtl/psr_cksum.sv
// Classic checksum accumulator: carry wraps back into the sum.
// Assumes clr and add are never high in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module psr_cksum (
    input  wire logic clock,
    input  wire logic nrst,
    psr_sum_if.engine sif
);
    logic [7:0] acc_q;
    logic [8:0] raw;
    logic [7:0] acc_d;
    assign raw   = {1'b0, acc_q} + {1'b0, sif.din};
    assign acc_d = sif.clr ? 8'h00 : (sif.add ? raw[7:0] + {7'h00, raw[8]} : acc_q);
    assign sif.sum = ~acc_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
        end
    end
endmodule
`default_nettype wire

//--- rtl/psr_frames.sv
// Slave handler for position and full status read frames.
// Assumes a byte layer: headers, received bytes and byte requests
// arrive as one-cycle pulses on this clock.
`timescale 1ns/1ps
`default_nettype none
module psr_frames #(
    parameter logic [3:0] DEVICE_ID = 4'h5 // Arbitrary identification value
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    // Byte layer
    input  wire logic        hdr_valid,
    input  wire logic [7:0]  hdr_pid,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_take,
    // Device state
    input  wire logic [11:0] flag_set,
    input  wire logic        end_switch_flag,
    input  wire logic [1:0]  temp_info,
    input  wire logic [2:0]  motion_state,
    input  wire logic [15:0] actual_position,
    input  wire logic [39:0] full_aux_a,
    input  wire logic [39:0] full_aux_b,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             irq
);
    // =====================================================
    // State
    psr_pkg::psr_state_t state_q;
    psr_pkg::psr_pend_t  pend_q;
    logic                long_q;
    logic [3:0]          idx_q;
    logic [7:0]          buf_q [0:7];
    logic [6:0]          node_q;
    logic [4:0]          dyn_id_q;
    logic [2:0]          irq_st_q;
    logic [2:0]          irq_mask_q;
    logic [11:0]         flags_q;
    logic [11:0]         snap_flags_q;
    logic [15:0]         snap_pos_q;
    logic                snap_endsw_q;
    logic [1:0]          snap_tinfo_q;
    logic [2:0]          snap_motion_q;
    logic                snap_lerr_q;
    logic                tx_valid_q;
    logic [7:0]          tx_data_q;
    logic [7:0]          rdata_q;

    psr_sum_if sif ();
    psr_cksum u_cksum (
        .clock (clock),
        .nrst  (nrst),
        .sif   (sif)
    );

    // =====================================================
    // Header decode
    wire  [5:0] hdr_id = hdr_pid[5:0];
    logic [7:0] pid_calc;
    psr_parity u_parity (
        .id  (hdr_id),
        .pid (pid_calc)
    );
    wire par_ok    = (pid_calc == hdr_pid);
    wire is_short  = par_ok && !hdr_id[5] && (hdr_id[4:0] == dyn_id_q);
    wire is_long   = par_ok && (hdr_id == psr_pkg::ID_LONG_PREP);
    wire is_read   = par_ok && (hdr_id == psr_pkg::ID_READ) &&
                     (pend_q != psr_pkg::PEND_NONE);
    wire hdr_start_tx = hdr_valid && is_read;
    wire hdr_start_rx = hdr_valid && (is_short || is_long);

    // =====================================================
    // Preparing frame checks at the checksum byte
    wire       in_rx     = (state_q == psr_pkg::ST_RX);
    wire [3:0] rx_last   = long_q ? psr_pkg::LAST_LONG : psr_pkg::LAST_SHORT;
    wire       rx_data_b = in_rx && rx_valid && (idx_q != rx_last);
    wire       rx_end    = in_rx && rx_valid && (idx_q == rx_last);
    wire [7:0] pad_and   = buf_q[3] & buf_q[4] & buf_q[5] & buf_q[6] & buf_q[7];
    wire [7:0] cmd_b     = long_q ? buf_q[1] : buf_q[0];
    wire [7:0] adr_b     = long_q ? buf_q[2] : buf_q[1];
    wire       mark_ok   = !long_q ||
                           ((buf_q[0] == psr_pkg::APP_MARKER) &&
                            (pad_and == psr_pkg::PAD_BYTE));
    wire       cks_ok    = (rx_data == sif.sum);
    wire       cmd_pos   = (cmd_b[6:0] == psr_pkg::CMD_POS);
    wire       cmd_full  = (cmd_b[6:0] == psr_pkg::CMD_FULL);
    wire       frame_ok  = cks_ok && mark_ok && cmd_b[7] && adr_b[7] &&
                           (cmd_pos || cmd_full);
    wire       addr_hit  = (adr_b[6:0] == node_q);
    wire       prep_ok   = rx_end && frame_ok && addr_hit;
    wire       lerr_ev   = (hdr_valid && !par_ok) || (rx_end && !cks_ok);

    // =====================================================
    // Response bytes
    wire       in_tx    = (state_q == psr_pkg::ST_TX);
    wire       tx_done  = in_tx && tx_valid_q && tx_take && (idx_q == psr_pkg::LAST_RESP);
    wire       tx_adv   = in_tx && tx_valid_q && tx_take && (idx_q != psr_pkg::LAST_RESP);
    wire       tx_load  = in_tx && !tx_valid_q;
    wire       flag_clr = hdr_start_tx && (pend_q == psr_pkg::PEND_FULL1);
    wire [7:0] flag_byte = {snap_flags_q[psr_pkg::F_VDD], snap_flags_q[psr_pkg::F_LOST],
                            snap_flags_q[psr_pkg::F_EDEF], snap_flags_q[psr_pkg::F_UVLO],
                            snap_flags_q[psr_pkg::F_TSHD], snap_flags_q[psr_pkg::F_TWRN],
                            snap_tinfo_q};
    wire [7:0] id_byte  = {DEVICE_ID, 1'b1, snap_flags_q[psr_pkg::F_UVLO2],
                           snap_flags_q[psr_pkg::F_UVLO3], snap_lerr_q};
    wire [7:0] mot_byte = {snap_motion_q, snap_endsw_q, snap_flags_q[psr_pkg::F_OVCX],
                           snap_flags_q[psr_pkg::F_OVCY], snap_flags_q[psr_pkg::F_STALL],
                           1'b0};
    wire [7:0] own_byte = {1'b1, node_q};
    logic [7:0][7:0] pos_w;
    logic [7:0][7:0] full1_w;
    logic [7:0][7:0] full2_w;
    // Position returned as raw 16-bit two's complement, high byte first
    assign pos_w   = {psr_pkg::PAD_BYTE, psr_pkg::PAD_BYTE, psr_pkg::PAD_BYTE, id_byte,
                      flag_byte, snap_pos_q[7:0], snap_pos_q[15:8],
                      {snap_endsw_q, node_q}};
    assign full1_w = {{full_aux_a[7:4], snap_flags_q[psr_pkg::F_UVLO2], full_aux_a[2:0]},
                      full_aux_a[15:8], mot_byte, flag_byte, full_aux_a[23:16],
                      full_aux_a[31:24], full_aux_a[39:32], own_byte};
    assign full2_w = {{snap_flags_q[psr_pkg::F_ABS], full_aux_b[6:0]}, full_aux_b[15:8],
                      full_aux_b[23:16], full_aux_b[31:24], full_aux_b[39:32],
                      snap_pos_q[7:0], snap_pos_q[15:8], own_byte};
    wire [2:0] sel = idx_q[2:0];
    wire [7:0] data_sel = (pend_q == psr_pkg::PEND_POS)   ? pos_w[sel] :
                          (pend_q == psr_pkg::PEND_FULL1) ? full1_w[sel] : full2_w[sel];
    wire [7:0] tx_byte  = (idx_q == psr_pkg::LAST_RESP) ? sif.sum : data_sel;

    assign sif.clr = hdr_valid;
    assign sif.add = rx_data_b || tx_adv;
    assign sif.din = in_tx ? tx_data_q : rx_data;

    assign tx_valid = tx_valid_q;
    assign tx_data  = tx_data_q;

    // =====================================================
    // Frame sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= psr_pkg::ST_IDLE;
            long_q  <= 1'b0;
            idx_q   <= 4'h0;
        end else if (hdr_valid) begin
            state_q <= hdr_start_tx ? psr_pkg::ST_TX :
                       hdr_start_rx ? psr_pkg::ST_RX : psr_pkg::ST_IDLE;
            long_q  <= is_long;
            idx_q   <= 4'h0;
        end else if (rx_end || tx_done) begin
            state_q <= psr_pkg::ST_IDLE;
        end else if (rx_data_b || tx_adv) begin
            idx_q   <= idx_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rx_data_b && !idx_q[3]) begin
            buf_q[idx_q[2:0]] <= rx_data;
        end
    end

    // Pending answer: second full status answer waits for the next read, then clears
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_q <= psr_pkg::PEND_NONE;
        end else if (rx_end && frame_ok && !addr_hit) begin
            pend_q <= psr_pkg::PEND_NONE;
        end else if (prep_ok) begin
            pend_q <= cmd_full ? psr_pkg::PEND_FULL1 : psr_pkg::PEND_POS;
        end else if (tx_done) begin
            pend_q <= (pend_q == psr_pkg::PEND_FULL1) ? psr_pkg::PEND_FULL2 :
                      psr_pkg::PEND_NONE;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else if (hdr_valid || tx_done) begin
            tx_valid_q <= 1'b0;
        end else if (tx_adv) begin
            tx_valid_q <= 1'b0;
        end else if (tx_load) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= tx_byte;
        end
    end

    // Snapshot before the clear so the answer shows the pre-clear state
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            snap_flags_q  <= 12'h000;
            snap_pos_q    <= 16'h0000;
            snap_endsw_q  <= 1'b0;
            snap_tinfo_q  <= 2'h0;
            snap_motion_q <= 3'h0;
            snap_lerr_q   <= 1'b0;
        end else if (hdr_start_tx) begin
            snap_flags_q  <= flags_q;
            snap_pos_q    <= actual_position;
            snap_endsw_q  <= end_switch_flag;
            snap_tinfo_q  <= temp_info;
            snap_motion_q <= motion_state;
            snap_lerr_q   <= irq_st_q[psr_pkg::IRQ_LERR];
        end
    end

    // =====================================================
    // Latched flags: a set in the clearing cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < psr_pkg::NFLAGS; gi++) begin : g_flag
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    flags_q[gi] <= 1'b0;
                end else begin
                    flags_q[gi] <= flag_set[gi] | (flags_q[gi] & ~flag_clr);
                end
            end
        end
    endgenerate

    // =====================================================
    // Register port and interrupt
    wire       wr_node = reg_wr && (reg_addr == psr_pkg::REG_NODE);
    wire       wr_dyn  = reg_wr && (reg_addr == psr_pkg::REG_DYN_ID);
    wire       wr_st   = reg_wr && (reg_addr == psr_pkg::REG_IRQ_ST);
    wire       wr_mask = reg_wr && (reg_addr == psr_pkg::REG_IRQ_MASK);
    wire [2:0] st_clr  = wr_st ? reg_wdata[2:0] : 3'h0;
    wire [2:0] st_ev   = {lerr_ev, tx_done, prep_ok};
    wire [7:0] rd_mux  = (reg_addr == psr_pkg::REG_NODE)     ? {1'b0, node_q} :
                         (reg_addr == psr_pkg::REG_DYN_ID)   ? {3'h0, dyn_id_q} :
                         (reg_addr == psr_pkg::REG_IRQ_ST)   ? {5'h00, irq_st_q} :
                         (reg_addr == psr_pkg::REG_IRQ_MASK) ? {5'h00, irq_mask_q} :
                         (reg_addr == psr_pkg::REG_FLAGS_LO) ? flags_q[7:0] :
                         (reg_addr == psr_pkg::REG_FLAGS_HI) ? {4'h0, flags_q[11:8]} :
                         (reg_addr == psr_pkg::REG_DEV_ID)   ? {4'h0, DEVICE_ID} : 8'h00;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            node_q     <= psr_pkg::RST_NODE;
            dyn_id_q   <= psr_pkg::RST_DYN_ID;
            irq_mask_q <= psr_pkg::RST_MASK;
            irq_st_q   <= 3'h0;
            rdata_q    <= 8'h00;
        end else begin
            if (wr_node) begin
                node_q <= reg_wdata[6:0];
            end
            if (wr_dyn) begin
                dyn_id_q <= reg_wdata[4:0];
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[2:0];
            end
            irq_st_q <= (irq_st_q & ~st_clr) | st_ev;
            rdata_q  <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = |(irq_st_q & irq_mask_q);
endmodule
`default_nettype wire

//--- bench/psr_frames_properties.sv
// Checker for the frame handler, bound to its top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module psr_frames_properties #(
    parameter logic [3:0] DEVICE_ID = 4'h5 // Arbitrary identification value
) (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       hdr_valid,
    input wire logic       rx_valid,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_take,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Answer byte index, running checksum, node address copy
    logic [3:0] idx_q;
    logic [7:0] sum_q;
    logic [6:0] node_q;
    logic [8:0] acc;
    logic       taken;
    assign acc   = {1'b0, sum_q} + {1'b0, tx_data};
    assign taken = tx_valid && tx_take && !hdr_valid;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            idx_q  <= 4'h0;
            sum_q  <= 8'h00;
            node_q <= 7'h00;
        end else begin
            if (hdr_valid) begin
                idx_q <= 4'h0;
                sum_q <= 8'h00;
            end else if (taken) begin
                idx_q <= idx_q + 4'h1;
                sum_q <= acc[7:0] + {7'h00, acc[8]};
            end
            if (reg_wr && reg_addr == psr_pkg::REG_NODE) node_q <= reg_wdata[6:0];
        end
    end
    a_rise_cause: assert property ($rose(tx_valid) |-> $past(hdr_valid, 2) || $past(tx_take, 2))
        else $error("answer byte offered without header or take");
    a_tx_holds: assert property (tx_valid && !tx_take && !hdr_valid |=> tx_valid && $stable(tx_data))
        else $error("answer byte changed before it was taken");
    a_next_byte: assert property (taken && idx_q < 4'h8 |=> !tx_valid ##1 tx_valid)
        else $error("next answer byte not offered two cycles after take");
    a_frame_end: assert property (taken && idx_q == 4'h8 |=> !tx_valid [*3])
        else $error("answer went on after its checksum byte");
    a_frame_cks: assert property (tx_valid && idx_q == 4'h8 |-> tx_data == ~sum_q)
        else $error("answer checksum wrong");
    a_byte_count: assert property (tx_valid |-> idx_q <= 4'h8)
        else $error("answer longer than nine bytes");
    a_answer_addr: assert property (tx_valid && idx_q == 4'h0 |-> tx_data[6:0] == node_q)
        else $error("first answer byte lacks the node address");
    a_dev_id_read: assert property (reg_rd && reg_addr == psr_pkg::REG_DEV_ID
                                    |=> reg_rdata == {4'h0, DEVICE_ID})
        else $error("identification register read wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_status_clear: assert property (reg_wr && reg_addr == psr_pkg::REG_IRQ_ST && reg_wdata[2:0] == 3'h7
        && !rx_valid && !tx_take && !$past(rx_valid) && !$past(tx_take) |=> !irq)
        else $error("interrupt stayed high after clearing all status bits");
endmodule
bind psr_frames psr_frames_properties #(.DEVICE_ID(DEVICE_ID)) psr_frames_properties_i (
    .clock(clock), .nrst(nrst), .hdr_valid(hdr_valid), .rx_valid(rx_valid),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
);
`default_nettype wire

//--- bench/psr_master.sv
// Bus master model at the byte layer: headers, frames, answer fetch.
// Assumes the caller waits for reset release before using its tasks.
`timescale 1ns/1ps
`default_nettype none
module psr_master (
    input  wire logic       clock,
    output logic            hdr_valid,
    output logic      [7:0] hdr_pid,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_take
);
    int         slow = 0;
    logic [7:0] d  [9];
    logic [7:0] rb [9];
    initial {hdr_valid, hdr_pid, rx_valid, rx_data, tx_take} = 19'h0;
    // ==========================================================
    // Frame building
    function automatic logic [7:0] pid_of(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction
    function automatic logic [7:0] cks(input logic [7:0] a [9], input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++) begin
            s = {1'b0, s[7:0]} + {1'b0, a[i]};
            s = {1'b0, s[7:0]} + {8'h00, s[8]};
        end
        return ~s[7:0];
    endfunction
    task automatic header(input logic [5:0] id);
        @(posedge clock);
        hdr_valid <= 1'b1;
        hdr_pid   <= pid_of(id);
        @(posedge clock);
        hdr_valid <= 1'b0;
        hdr_pid   <= ~pid_of(id);
    endtask
    // Bad checksum flips its lowest bit
    task automatic send(input logic [5:0] id, input int n, input logic bad);
        logic [7:0] c;
        c = cks(d, n) ^ {7'h00, bad};
        header(id);
        for (int i = 0; i <= n; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= (i == n) ? c : d[i];
            @(posedge clock);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask
    task automatic prep_short(input logic [4:0] id, input logic [6:0] cmd, input logic [6:0] ad,
                              input logic bad);
        d[0] = {1'b1, cmd};
        d[1] = {1'b1, ad};
        send({1'b0, id}, 2, bad);
    endtask
    task automatic prep_long(input logic [6:0] cmd, input logic [6:0] ad, input logic bad);
        d = '{8'h80, {1'b1, cmd}, {1'b1, ad}, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
        send(6'h3c, 8, bad);
    endtask
    // Reading header, then take bytes while offered, optionally stalling
    task automatic fetch(output int got);
        int w;
        got = 0;
        header(6'h3d);
        for (int i = 0; i < 9; i++) begin
            w = 0;
            do begin
                @(posedge clock);
                w++;
            end while (tx_valid !== 1'b1 && w < 30);
            if (tx_valid !== 1'b1) return;
            repeat (slow) @(posedge clock);
            rb[i] = tx_data;
            tx_take <= 1'b1;
            @(posedge clock);
            tx_take <= 1'b0;
            got++;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the position and full status frame handler.
// Assumes the master model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [3:0] DEV = 4'h9; // Arbitrary identification value
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        hdr_valid, rx_valid, tx_valid, tx_take, irq;
    logic [7:0]  hdr_pid, rx_data, tx_data, reg_rdata;
    logic [7:0]  reg_wdata = 8'h00;
    logic [2:0]  reg_addr = 3'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [11:0] flag_set = 12'h000;
    logic        endsw = 1'b1;
    logic [15:0] pos = 16'h8123;
    logic [39:0] aux_b = 40'h11223344f5;
    logic [7:0]  e [8];
    int          n_mismatch = 0;
    int          checks = 0;
    int          got;
    always #12.5 clock = ~clock;
    psr_frames #(.DEVICE_ID(DEV)) psr_frames_i (
        .clock(clock), .nrst(nrst), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_take(tx_take), .flag_set(flag_set), .end_switch_flag(endsw), .temp_info(2'h2),
        .motion_state(3'h5), .actual_position(pos), .full_aux_a(40'h0123456789),
        .full_aux_b(aux_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    psr_master psr_master_i (
        .clock(clock), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take));
    // ==========================================================
    // Compare, register access and verdict
    task automatic cmp8(input logic [7:0] g, input logic [7:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %0t: byte %h expected %h", $time, g, x);
        end
    endtask
    task automatic cmpn(input int g, input int x);
        checks++;
        if (g != x) begin
            n_mismatch++;
            $display("Error %0t: count %0d expected %0d", $time, g, x);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic x);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1 cmp8({7'h00, irq}, {7'h00, x});
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 cmp8(reg_rdata, x);
    endtask
    task automatic exp_pos(input logic [11:0] f, input logic lerr);
        e = '{{endsw, 7'h12}, pos[15:8], pos[7:0], {f[5:0], 2'h2}, {DEV, 1'b1, f[6], f[7], lerr},
              8'hff, 8'hff, 8'hff};
    endtask
    task automatic chk_frame(input logic [7:0] care);
        cmpn(got, 9);
        for (int i = 0; i < 8; i++)
            if (care[i]) cmp8(psr_master_i.rb[i], e[i]);
        cmp8(psr_master_i.rb[8], psr_master_i.cks(psr_master_i.rb, 8));
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        close_out;
    end
    // ==========================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(psr_pkg::REG_DEV_ID, {4'h0, DEV});
        rd(3'h7, 8'h00);
        rd(psr_pkg::REG_NODE, 8'h00);
        wr(psr_pkg::REG_NODE, 8'h12, 1'b0);
        wr(psr_pkg::REG_DYN_ID, 8'h05, 1'b0);
        wr(psr_pkg::REG_IRQ_MASK, 8'h07, 1'b0);
        @(posedge clock);
        flag_set <= 12'h8b5;
        @(posedge clock);
        flag_set <= 12'h000;
        rd(psr_pkg::REG_FLAGS_LO, 8'hb5);
        rd(psr_pkg::REG_FLAGS_HI, 8'h08);
        psr_master_i.prep_short(5'h05, psr_pkg::CMD_POS, 7'h12, 1'b0);
        rd(psr_pkg::REG_IRQ_ST, 8'h01);
        wr(psr_pkg::REG_IRQ_ST, 8'h01, 1'b0);
        psr_master_i.slow = 3;
        psr_master_i.fetch(got);
        exp_pos(12'h8b5, 1'b0);
        chk_frame(8'hff);
        rd(psr_pkg::REG_FLAGS_LO, 8'hb5);
        rd(psr_pkg::REG_IRQ_ST, 8'h02);
        wr(psr_pkg::REG_IRQ_MASK, 8'h00, 1'b0);
        wr(psr_pkg::REG_IRQ_MASK, 8'h07, 1'b1);
        wr(psr_pkg::REG_IRQ_ST, 8'h02, 1'b0);
        psr_master_i.fetch(got);
        cmpn(got, 0);
        psr_master_i.prep_long(psr_pkg::CMD_POS, 7'h12, 1'b1);
        rd(psr_pkg::REG_IRQ_ST, 8'h04);
        psr_master_i.prep_long(psr_pkg::CMD_POS, 7'h12, 1'b0);
        psr_master_i.fetch(got);
        exp_pos(12'h8b5, 1'b1);
        chk_frame(8'hff);
        wr(psr_pkg::REG_IRQ_ST, 8'h07, 1'b0);
        psr_master_i.prep_short(5'h05, 7'h05, 7'h12, 1'b0);
        rd(psr_pkg::REG_IRQ_ST, 8'h00);
        psr_master_i.prep_short(5'h05, psr_pkg::CMD_POS, 7'h13, 1'b0);
        psr_master_i.fetch(got);
        cmpn(got, 0);
        psr_master_i.slow = 0;
        psr_master_i.prep_long(psr_pkg::CMD_FULL, 7'h12, 1'b0);
        psr_master_i.fetch(got);
        e = '{8'h92, 8'h01, 8'h23, 8'h45, 8'hd6, 8'hb0, 8'h67, 8'h81};
        chk_frame(8'hff);
        rd(psr_pkg::REG_FLAGS_LO, 8'h00);
        rd(psr_pkg::REG_FLAGS_HI, 8'h00);
        psr_master_i.fetch(got);
        e = '{8'h92, pos[15:8], pos[7:0], aux_b[39:32], aux_b[31:24], aux_b[23:16],
              aux_b[15:8], 8'h75};
        chk_frame(8'hff);
        psr_master_i.prep_short(5'h05, psr_pkg::CMD_FULL, 7'h12, 1'b0);
        psr_master_i.fetch(got);
        chk_frame(8'h01);
        @(posedge clock);
        pos <= 16'h7ffe;
        endsw <= 1'b0;
        psr_master_i.prep_short(5'h05, psr_pkg::CMD_POS, 7'h12, 1'b0);
        psr_master_i.fetch(got);
        exp_pos(12'h000, 1'b0);
        chk_frame(8'hff);
        close_out;
    end
endmodule
`default_nettype wire
